// ==== core/lrp_ctrl.sv ====
// lo routing, synthesiser enable, phase detector and lock detect
// assumes reference and lo edges arrive asynchronously on pins
module lrp_ctrl
    import lrp_pkg::*;
#(
    parameter int LOCK_COUNT = LOCK_COUNT_DEF,
    parameter int DW         = DIV_W
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RSTN,
    input  wire logic              GEN_RESET,
    input  wire logic              GC_WE,
    input  wire logic [7:0]        GC_DATA,
    input  wire logic              RC_WE,
    input  wire logic [7:0]        RC_DATA,
    input  wire logic              BAND_WE,
    input  wire logic [3:0]        BAND_DATA,
    input  wire logic              OFS_WE,
    input  wire logic [5:0]        OFS_I_DATA,
    input  wire logic [5:0]        OFS_Q_DATA,
    input  wire logic              DIV_WE,
    input  wire logic [7:0]        DIV_CTRL_DATA,
    input  wire logic [DW-1:0]     M_DATA,
    input  wire logic [DW-1:0]     R_DATA,
    input  wire logic              AMP_I_EN,
    input  wire logic              AMP_Q_EN,
    input  wire logic              REFERENCE_INPUT,
    input  wire logic              EXTERNAL_LO_INPUT,
    output logic [7:0]             GEN_CTRL_RD,
    output logic [7:0]             DIV_STATUS_RD,
    output logic                   IQ_BALANCE_FIX_ENABLE,
    output logic [3:0]             CORRECTION_BAND_SELECT,
    output lrp_offset_t            OFFSET_I,
    output lrp_offset_t            OFFSET_Q,
    output logic                   ONCHIP_OSC_POWER,
    output logic                   SYNTH_POWER,
    output logic                   DEMOD_POWER,
    output logic                   LO_DIVIDE_SELECT,
    output logic                   EXT_LO_ENABLE,
    output logic                   AMP_I_POWER,
    output logic                   AMP_Q_POWER,
    output logic                   PUMP_UP,
    output logic                   PUMP_DOWN,
    output logic                   PUMP_OE,
    output logic                   LOCK_DETECT
);
    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [7:0]    gc_r, gc_nxt, rc_r, rc_nxt, dv_r, dv_nxt;
    logic [3:0]    band_r, band_nxt;
    logic [5:0]    oi_r, oi_nxt, oq_r, oq_nxt;
    logic [DW-1:0] m_r, m_nxt, rdiv_r, rdiv_nxt;
    logic          clr;

    assign clr = !RSTN || GEN_RESET;

    always_comb begin
        gc_nxt   = gc_r;
        rc_nxt   = rc_r;
        dv_nxt   = dv_r;
        band_nxt = band_r;
        oi_nxt   = oi_r;
        oq_nxt   = oq_r;
        m_nxt    = m_r;
        rdiv_nxt = rdiv_r;
        if (clr) begin
            gc_nxt   = REG_RESET;
            rc_nxt   = REG_RESET;
            dv_nxt   = REG_RESET;
            band_nxt = BAND_RESET;
            oi_nxt   = '0;
            oq_nxt   = '0;
            m_nxt    = '0;
            rdiv_nxt = '0;
        end else begin
            if (GC_WE) gc_nxt = GC_DATA;
            if (RC_WE) rc_nxt = RC_DATA;
            if (BAND_WE) band_nxt = BAND_DATA;
            if (OFS_WE) begin
                oi_nxt = OFS_I_DATA;
                oq_nxt = OFS_Q_DATA;
            end
            if (DIV_WE) begin
                dv_nxt   = DIV_CTRL_DATA;
                m_nxt    = M_DATA;
                rdiv_nxt = R_DATA;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        gc_r   <= gc_nxt;
        rc_r   <= rc_nxt;
        dv_r   <= dv_nxt;
        band_r <= band_nxt;
        oi_r   <= oi_nxt;
        oq_r   <= oq_nxt;
        m_r    <= m_nxt;
        rdiv_r <= rdiv_nxt;
    end

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [2:0] ref_s_r, lo_s_r;
    logic       ref_edge, lo_edge, run;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ref_s_r <= '0;
            lo_s_r  <= '0;
        end else begin
            ref_s_r <= {ref_s_r[1:0], REFERENCE_INPUT};
            lo_s_r  <= {lo_s_r[1:0], EXTERNAL_LO_INPUT};
        end
    end

    assign ref_edge = ref_s_r[1] && !ref_s_r[2];
    assign lo_edge  = lo_s_r[1] && !lo_s_r[2];
    assign run      = gc_r[GC_SYNTH_POWER] && dv_r[DV_SYNTH_EN];

    // ------------------------------------------------------------
    // dividers, phase detector, lock detect
    // ------------------------------------------------------------
    logic [DW-1:0] rc_cnt_r, rc_cnt_nxt, mc_cnt_r, mc_cnt_nxt;
    logic          rt, mt, up_nxt, dn_nxt, up_r, dn_r;
    logic [7:0]    good_r, good_nxt;
    lrp_lock_t     st_r, st_nxt;

    always_comb begin
        rc_cnt_nxt = rc_cnt_r;
        mc_cnt_nxt = mc_cnt_r;
        rt = 1'b0;
        mt = 1'b0;
        if (ref_edge) begin
            if (rc_cnt_r + 1'b1 >= rdiv_r) begin
                rc_cnt_nxt = '0;
                rt = 1'b1;
            end else begin
                rc_cnt_nxt = rc_cnt_r + 1'b1;
            end
        end
        if (lo_edge) begin
            if (mc_cnt_r + 1'b1 >= m_r) begin
                mc_cnt_nxt = '0;
                mt = 1'b1;
            end else begin
                mc_cnt_nxt = mc_cnt_r + 1'b1;
            end
        end
        up_nxt = up_r;
        dn_nxt = dn_r;
        if (rt && mt) begin
            up_nxt = 1'b0;
            dn_nxt = 1'b0;
        end else if (rt) begin
            if (dn_r) dn_nxt = 1'b0;
            else up_nxt = 1'b1;
        end else if (mt) begin
            if (up_r) up_nxt = 1'b0;
            else dn_nxt = 1'b1;
        end
        good_nxt = good_r;
        st_nxt   = st_r;
        case (st_r)
            ST_OFF: begin
                good_nxt = '0;
                if (run) st_nxt = ST_HUNT;
            end
            ST_HUNT: begin
                if (rt || mt) begin
                    if (rt && mt) good_nxt = good_r + 1'b1;
                    else good_nxt = '0;
                end
                if (good_r >= 8'(LOCK_COUNT)) st_nxt = ST_LOCK;
            end
            ST_LOCK: begin
                if (rt != mt) begin
                    st_nxt   = ST_HUNT;
                    good_nxt = '0;
                end
            end
            default: st_nxt = ST_OFF;
        endcase
        if (!run) begin
            rc_cnt_nxt = '0;
            mc_cnt_nxt = '0;
            up_nxt     = 1'b0;
            dn_nxt     = 1'b0;
            st_nxt     = ST_OFF;
            good_nxt   = '0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (clr) begin
            rc_cnt_r <= '0;
            mc_cnt_r <= '0;
            up_r     <= 1'b0;
            dn_r     <= 1'b0;
            good_r   <= '0;
            st_r     <= ST_OFF;
        end else begin
            rc_cnt_r <= rc_cnt_nxt;
            mc_cnt_r <= mc_cnt_nxt;
            up_r     <= up_nxt;
            dn_r     <= dn_nxt;
            good_r   <= good_nxt;
            st_r     <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        GEN_CTRL_RD            <= gc_r;
        DIV_STATUS_RD          <= '0;
        DIV_STATUS_RD[DS_LOCK] <= (st_r == ST_LOCK);
        LOCK_DETECT            <= (st_r == ST_LOCK);
        IQ_BALANCE_FIX_ENABLE  <= rc_r[RC_FIX_ENABLE];
        CORRECTION_BAND_SELECT <= band_r;
        OFFSET_I               <= oi_r;
        OFFSET_Q               <= oq_r;
        ONCHIP_OSC_POWER       <= gc_r[GC_OSC_POWER];
        SYNTH_POWER            <= run;
        DEMOD_POWER            <= gc_r[GC_DEMOD_POWER];
        EXT_LO_ENABLE          <= !gc_r[GC_OSC_POWER];
        LO_DIVIDE_SELECT       <= gc_r[GC_LO_DIV2];
        AMP_I_POWER            <= gc_r[GC_DIFAMP] || AMP_I_EN;
        AMP_Q_POWER            <= gc_r[GC_DIFAMP] || AMP_Q_EN;
        PUMP_UP                <= up_r && run;
        PUMP_DOWN              <= dn_r && run;
        PUMP_OE                <= run && !dv_r[DV_PUMP_HIZ];
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_reset_clear: assert property (@(posedge CORE_CLK)
        $past(clr) |-> gc_r == REG_RESET && band_r == BAND_RESET)
        else $error("control not cleared by reset");
    chk_fix_follow: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        1'b1 |=> IQ_BALANCE_FIX_ENABLE == $past(rc_r[RC_FIX_ENABLE]))
        else $error("fix enable mismatch");
    chk_synth_and: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !(gc_r[GC_SYNTH_POWER] && dv_r[DV_SYNTH_EN]) |=> !SYNTH_POWER)
        else $error("synth ran without both enables");
    chk_hiz_pump: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        dv_r[DV_PUMP_HIZ] |=> !PUMP_OE)
        else $error("pump driven in hiz mode");
    chk_lock_stat: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        DIV_STATUS_RD[DS_LOCK] == LOCK_DETECT)
        else $error("lock status bit mismatch");
    chk_lock_drop: assert property (@(posedge CORE_CLK) disable iff (clr)
        st_r == ST_LOCK && run && rt != mt |=> ##1 !LOCK_DETECT)
        else $error("lock kept after misalignment");
    chk_slow_up: assert property (@(posedge CORE_CLK) disable iff (clr)
        run && rt && !mt && !dn_r |=> up_r)
        else $error("no up pulse when lo slow");
    chk_div_mode: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        1'b1 |=> LO_DIVIDE_SELECT == $past(gc_r[GC_LO_DIV2]))
        else $error("lo divide select mismatch");
    chk_amp_or: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        gc_r[GC_DIFAMP] |=> AMP_I_POWER && AMP_Q_POWER)
        else $error("amps not powered by general enable");
    chk_ofs_load: assert property (@(posedge CORE_CLK) disable iff (clr)
        OFS_WE |=> ##1 OFFSET_I == $past(OFS_I_DATA, 2))
        else $error("offset sources not loaded");
    chk_rate: assert property (@(posedge CORE_CLK) disable iff (clr)
        rt |-> rc_cnt_nxt == '0)
        else $error("reference divider not wrapped");
endmodule

// ==== core/lrp_pkg.sv ====
// package for the lo routing and synthesiser control block
// assumes one core clock and register bytes delivered as plain ports
package lrp_pkg;
    // general control bit positions
    localparam int GC_LO_DIV2     = 7;
    localparam int GC_DIFAMP      = 5;
    localparam int GC_OSC_POWER   = 3;
    localparam int GC_SYNTH_POWER = 2;
    localparam int GC_DEMOD_POWER = 1;
    // receive control / divider bit positions
    localparam int RC_FIX_ENABLE  = 6;
    localparam int DV_SYNTH_EN    = 7;
    localparam int DV_PUMP_HIZ    = 6;
    localparam int DS_LOCK        = 6;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [3:0] BAND_RESET  = 4'h0;
    localparam logic [3:0] BAND_GAIN   = 4'hF;
    localparam int LOCK_COUNT_DEF = 8;
    localparam int DIV_W          = 12;

    typedef struct packed {
        logic pos_60;
        logic pos_120;
        logic pos_180;
        logic neg_60;
        logic neg_120;
        logic neg_180;
    } lrp_offset_t;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_HUNT = 3'b010,
        ST_LOCK = 3'b100
    } lrp_lock_t;
endpackage

// ==== sim/lrp_osc_model.sv ====
// reference source and external oscillator model for lrp_ctrl
// assumes the block synchronises both pins to its core clock
module lrp_osc_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode,
    output logic            ref_pin,
    output logic            lo_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_r;
    always @(posedge clk) begin
        cnt_r <= rst_n ? cnt_r + 3'h1 : 3'h0;
    end
    assign ref_pin = cnt_r[2];
    // lo tracks the reference, stalls low, or runs fast
    always_comb begin
        case (mode)
            2'h0: lo_pin = cnt_r[2];
            2'h1: lo_pin = 1'h0;
            default: lo_pin = cnt_r[0];
        endcase
    end
endmodule

// ==== sim/lrp_ctrl_test.sv ====
// self-checking bench for lrp_ctrl against an integer model
// assumes one 250 MHz clock and register bytes as plain ports
module lrp_ctrl_test;
    import lrp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CORE_CLK = 0, RSTN = 0, GEN_RESET = 0;
    logic        AMP_I_EN = 0, AMP_Q_EN = 0;
    logic        REFERENCE_INPUT, EXTERNAL_LO_INPUT;
    logic [4:0]  we = 0;
    logic [1:0]  mode = 0;
    logic [7:0]  GEN_CTRL_RD, DIV_STATUS_RD;
    logic [3:0]  CORRECTION_BAND_SELECT;
    lrp_offset_t OFFSET_I, OFFSET_Q;
    logic        IQ_BALANCE_FIX_ENABLE, ONCHIP_OSC_POWER, SYNTH_POWER;
    logic        DEMOD_POWER, LO_DIVIDE_SELECT, EXT_LO_ENABLE;
    logic        AMP_I_POWER, AMP_Q_POWER, PUMP_UP, PUMP_DOWN;
    logic        PUMP_OE, LOCK_DETECT;
    int          fail_count = 0, num_checks = 0, n;
    int          m_gc, m_rc, m_band, m_oi, m_div;
    int          legal[4] = '{0, 2, 6, 14};

    always #2 CORE_CLK = ~CORE_CLK;

    lrp_ctrl #(.LOCK_COUNT(2)) lrp_ctrl_inst (
        .CORE_CLK, .RSTN, .GEN_RESET,
        .GC_WE(we[0]), .RC_WE(we[1]), .BAND_WE(we[2]), .OFS_WE(we[3]),
        .DIV_WE(we[4]), .GC_DATA(m_gc[7:0]), .RC_DATA(m_rc[7:0]),
        .BAND_DATA(m_band[3:0]), .OFS_I_DATA(m_oi[5:0]),
        .OFS_Q_DATA(m_oi[11:6]), .DIV_CTRL_DATA(m_div[7:0]),
        .M_DATA(m_div[19:8]), .R_DATA(m_div[31:20]),
        .AMP_I_EN, .AMP_Q_EN, .REFERENCE_INPUT, .EXTERNAL_LO_INPUT,
        .GEN_CTRL_RD, .DIV_STATUS_RD, .IQ_BALANCE_FIX_ENABLE,
        .CORRECTION_BAND_SELECT, .OFFSET_I, .OFFSET_Q, .ONCHIP_OSC_POWER,
        .SYNTH_POWER, .DEMOD_POWER, .LO_DIVIDE_SELECT, .EXT_LO_ENABLE,
        .AMP_I_POWER, .AMP_Q_POWER, .PUMP_UP, .PUMP_DOWN, .PUMP_OE,
        .LOCK_DETECT
    );

    lrp_osc_model lrp_osc_model_inst (
        .clk(CORE_CLK), .rst_n(RSTN), .mode,
        .ref_pin(REFERENCE_INPUT), .lo_pin(EXTERNAL_LO_INPUT)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string s, input logic [11:0] e,
                       input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask

    // write one register; ports settle two edges after the strobe
    task automatic wr(input int sel, input int v);
        @(posedge CORE_CLK);
        case (sel)
            0: m_gc <= v;
            1: m_rc <= v;
            2: m_band <= v;
            3: m_oi <= v;
            default: m_div <= v;
        endcase
        we <= 5'h01 << sel;
        @(posedge CORE_CLK);
        we <= 5'h00;
        repeat (2) @(posedge CORE_CLK);
        #1;
    endtask

    // polls just after each edge so the output has settled
    task automatic wait_for(input string s, ref logic sig, input logic v);
        int k;
        for (k = 0; k < 400 && sig !== v; k++) begin
            @(posedge CORE_CLK);
            #1;
        end
        chk(s, v, sig);
    endtask

    task automatic cmp_all;
        chk("gen ctrl", m_gc[7:0], GEN_CTRL_RD);
        chk("fix", m_rc[RC_FIX_ENABLE], IQ_BALANCE_FIX_ENABLE);
        chk("band", m_band[3:0], CORRECTION_BAND_SELECT);
        chk("ofs i", m_oi[5:0], OFFSET_I);
        chk("ofs q", m_oi[11:6], OFFSET_Q);
        chk("osc", m_gc[GC_OSC_POWER], ONCHIP_OSC_POWER);
        chk("ext lo", !m_gc[GC_OSC_POWER], EXT_LO_ENABLE);
        chk("synth", m_gc[2] & m_div[7], SYNTH_POWER);
        chk("demod", m_gc[GC_DEMOD_POWER], DEMOD_POWER);
        chk("div2", m_gc[GC_LO_DIV2], LO_DIVIDE_SELECT);
        chk("amp i", m_gc[5] | AMP_I_EN, AMP_I_POWER);
        chk("amp q", m_gc[5] | AMP_Q_EN, AMP_Q_POWER);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        n = $urandom(32'h7464);
        repeat (16) @(posedge CORE_CLK);
        RSTN <= 1'h1;
        repeat (2) @(posedge CORE_CLK);
        #1;
        cmp_all;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            @(posedge CORE_CLK);
            AMP_I_EN <= 1'($urandom);
            AMP_Q_EN <= 1'($urandom);
            wr(0, legal[i % 4] | ($urandom & 8'hA0));
            wr(4, ((i & 4) << 5) | 32'h00200200);
            wr(1, $urandom & 8'hDF);
            wr(2, $urandom);
            wr(3, $urandom);
            cmp_all;
        end
        wr(2, 15);
        cmp_all;
        $display("test registers done");
        @(posedge CORE_CLK);
        GEN_RESET <= 1'h1;
        @(posedge CORE_CLK);
        GEN_RESET <= 1'h0;
        repeat (2) @(posedge CORE_CLK);
        #1;
        {m_gc, m_rc, m_band, m_oi, m_div} = '0;
        cmp_all;
        $display("test general reset done");
        wr(0, 8'h86);
        wr(4, 32'h00200280);
        wait_for("lock", LOCK_DETECT, 1'h1);
        chk("lock bit", 1'h1, DIV_STATUS_RD[DS_LOCK]);
        chk("pump oe", 1'h1, PUMP_OE);
        @(posedge CORE_CLK);
        mode <= 2'h1;
        wait_for("pump up", PUMP_UP, 1'h1);
        wait_for("unlock", LOCK_DETECT, 1'h0);
        chk("unlock bit", 1'h0, DIV_STATUS_RD[DS_LOCK]);
        @(posedge CORE_CLK);
        mode <= 2'h2;
        wait_for("pump down", PUMP_DOWN, 1'h1);
        wr(4, 32'h002002C0);
        chk("pump hiz", 1'h0, PUMP_OE);
        $display("test synthesiser done");
        final_report;
    end

    initial begin
        #100000;
        fail_count++;
        final_report;
    end
endmodule
